//--- hw/bqf_pkg.sv
// constants shared by the biquad section and its output fifo
package bqf_pkg;
   // sample and coefficient word width
   localparam int DATA_W = 16;
   // fraction bits of the coefficient and scale format
   localparam int FRAC_W = 13;
   // number of feedforward taps
   localparam int TAPS = 3;
   // tap product width
   localparam int PROD_W = 32;
   // feedforward sum width
   localparam int SUM_W = 34;
   // sum times scale width
   localparam int SCL_W = 50;
   // width of the unsaturated result
   localparam int FULL_W = 40;
   // enabled cycles from capture to output
   localparam int LATENCY = 7;
   // saturation limits
   localparam logic signed [15:0] SAT_MAX = 16'sh7fff;
   localparam logic signed [15:0] SAT_MIN = 16'sh8000;
   // output stream fifo
   localparam int FIFO_DEPTH = 4;
   localparam int FIFO_W = 17;
endpackage

//--- hw/bqf_fifo.sv
// small valid/ready fifo for the filtered sample stream
`timescale 1ns/1ps
module bqf_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // filling side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // draining side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
   localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);

   logic [WIDTH-1:0] memQ [DEPTH]; // storage words
   logic [PW-1:0] wrQ, wrD; // write pointer
   logic [PW-1:0] rdQ, rdD; // read pointer
   logic [PW:0] cntQ, cntD; // words held
   logic push, pop;

   // honest full and empty from the word count
   assign inReady = (cntQ != FULL_CNT);
   assign outValid = (cntQ != '0);
   assign outData = memQ[rdQ];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   // pointer and count next values
   always_comb begin
      wrD = wrQ;
      rdD = rdQ;
      cntD = cntQ;
      if (push) begin
         wrD = (wrQ == LAST_IDX) ? '0 : wrQ + 1'b1;
      end
      if (pop) begin
         rdD = (rdQ == LAST_IDX) ? '0 : rdQ + 1'b1;
      end
      if (push && !pop) begin
         cntD = cntQ + 1'b1;
      end else if (pop && !push) begin
         cntD = cntQ - 1'b1;
      end
   end

   // pointer registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wrQ <= '0;
         rdQ <= '0;
         cntQ <= '0;
      end else begin
         wrQ <= wrD;
         rdQ <= rdD;
         cntQ <= cntD;
      end
   end

   // storage write, no reset needed on data
   always_ff @(posedge clk_sys) begin
      if (push) begin
         memQ[wrQ] <= inData;
      end
   end

   a_fifo_no_overrun: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cntQ <= FULL_CNT) else $error("fifo count beyond depth");
endmodule // bqf_fifo

//--- hw/bqf_core.sv
// pipelined second-order recursive filter section with saturating output
`timescale 1ns/1ps
// What this block does
// RULE1: capture sample and coefficients while enable high
// RULE2: output is scaled feedforward minus feedback terms
// RULE3: taps are signed with thirteen fraction bits
// RULE4: scale factor uses the same fixed format
// RULE5: samples are sixteen bit two's complement
// RULE6: flag overflow when result exceeds range
// RULE7: clamp to 32767 or -32768 on overflow
// RULE8: output appears seven enabled cycles later
// RULE9: new sample accepted every enabled cycle; the code refuses it while the output fifo is full
// RULE10: reset clears feedback registers to zero
// RULE11: user holds reset low one cycle first
// RULE12: output stream feeds another identical section
// RULE13: enable low holds every register unchanged; the code still drains the output fifo while enable is low
// RULE14: overflow flag aligned with its output sample
module bqf_core (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // sample enable
   input wire logic en,
   // scale and taps, signed fixed point
   input wire logic [15:0] gain_scale_in,
   input wire logic [15:0] ff_tap_zero_in,
   input wire logic [15:0] ff_tap_one_in,
   input wire logic [15:0] ff_tap_two_in,
   input wire logic [15:0] fb_tap_one_in,
   input wire logic [15:0] fb_tap_two_in,
   // sample in and out
   input wire logic [15:0] sampleIn,
   output logic [15:0] sampleOut,
   output logic overflowOut,
   output logic sampleOutValid,
   // room downstream; low stalls the section
   output logic sampleReady,
   // buffered output stream {overflow, sample}
   output logic streamValid,
   input wire logic streamReady,
   output logic [16:0] streamData
);
   localparam int DW = bqf_pkg::DATA_W;
   localparam int FW = bqf_pkg::FULL_W;

   logic adv; // pipeline moves this cycle
   logic fifoInReady; // fifo has room
   logic fifoPush; // sample leaves the last stage

   // capture stage
   logic signed [DW-1:0] xTapQ [bqf_pkg::TAPS]; // x[n], x[n-1], x[n-2]
   logic signed [DW-1:0] xTapD [bqf_pkg::TAPS];
   logic signed [DW-1:0] ffCoefQ [bqf_pkg::TAPS]; // b0..b2
   logic signed [DW-1:0] ffCoefD [bqf_pkg::TAPS];
   logic signed [DW-1:0] scaleQ, scaleD; // s0
   logic signed [DW-1:0] fbOneQ, fbOneD; // a1
   logic signed [DW-1:0] fbTwoQ, fbTwoD; // a2
   // arithmetic stages
   logic signed [bqf_pkg::PROD_W-1:0] prodQ [bqf_pkg::TAPS]; // tap products
   logic signed [bqf_pkg::PROD_W-1:0] prodD [bqf_pkg::TAPS];
   logic signed [bqf_pkg::SUM_W-1:0] sumQ, sumD; // feedforward sum
   logic signed [FW-1:0] scaledQ, scaledD; // sum times scale, realigned
   logic signed [bqf_pkg::SCL_W-1:0] scaleProd; // wide scale product
   logic signed [bqf_pkg::SUM_W-1:0] fbSum; // feedback product sum
   logic signed [FW-1:0] yFull; // unsaturated result
   logic ovfRaw; // result outside output range
   logic signed [DW-1:0] ySat; // saturated result
   // feedback and output stages
   logic signed [DW-1:0] yFbQ, yFbD; // y[n-1]
   logic signed [DW-1:0] yFb2Q, yFb2D; // y[n-2]
   logic ovfFbQ, ovfFbD;
   logic signed [DW-1:0] yD1Q, yD1D, yD2Q, yD2D, yOutQ, yOutD;
   logic ovfD1Q, ovfD1D, ovfD2Q, ovfD2D, ovfOutQ, ovfOutD;
   logic [bqf_pkg::LATENCY-1:0] validQ, validD; // filled stages
   logic outValidQ, outValidD; // sampleOut holds a real sample

   // stall only when the output fifo is full
   assign adv = en && fifoInReady;
   assign sampleReady = fifoInReady;
   // the word pushed is the one that the same edge loads into sampleOut
   assign fifoPush = adv && validQ[bqf_pkg::LATENCY-1];

   // per tap product, signed fixed point times signed sample
   genvar t;
   generate
      for (t = 0; t < bqf_pkg::TAPS; t++) begin : g_tap
         // RULE3 signed tap products
         assign prodD[t] = adv ? xTapQ[t] * ffCoefQ[t] : prodQ[t];
      end
   endgenerate

   // next values of the pipeline except the tap products
   always_comb begin
      // RULE13 hold when idle
      xTapD = xTapQ;
      ffCoefD = ffCoefQ;
      scaleD = scaleQ;
      fbOneD = fbOneQ;
      fbTwoD = fbTwoQ;
      sumD = sumQ;
      scaledD = scaledQ;
      yFbD = yFbQ;
      yFb2D = yFb2Q;
      ovfFbD = ovfFbQ;
      yD1D = yD1Q;
      yD2D = yD2Q;
      yOutD = yOutQ;
      ovfD1D = ovfD1Q;
      ovfD2D = ovfD2Q;
      ovfOutD = ovfOutQ;
      validD = validQ;
      outValidD = outValidQ;
      // RULE4 scale realigned by fraction bits
      scaleProd = sumQ * scaleQ;
      // RULE2 feedback from the two previous outputs
      fbSum = bqf_pkg::SUM_W'(fbOneQ * yFbQ) + bqf_pkg::SUM_W'(fbTwoQ * yFb2Q);
      yFull = scaledQ - FW'(fbSum >>> bqf_pkg::FRAC_W);
      // RULE6 range check
      ovfRaw = (yFull > FW'(bqf_pkg::SAT_MAX)) || (yFull < FW'(bqf_pkg::SAT_MIN));
      // RULE7 clamp rather than wrap
      if (yFull > FW'(bqf_pkg::SAT_MAX)) begin
         ySat = bqf_pkg::SAT_MAX;
      end else if (yFull < FW'(bqf_pkg::SAT_MIN)) begin
         ySat = bqf_pkg::SAT_MIN;
      end else begin
         ySat = yFull[DW-1:0];
      end
      // RULE1 capture on enabled edge
      if (adv) begin
         xTapD[0] = sampleIn;
         xTapD[1] = xTapQ[0];
         xTapD[2] = xTapQ[1];
         ffCoefD[0] = ff_tap_zero_in;
         ffCoefD[1] = ff_tap_one_in;
         ffCoefD[2] = ff_tap_two_in;
         scaleD = gain_scale_in;
         fbOneD = fb_tap_one_in;
         fbTwoD = fb_tap_two_in;
         sumD = bqf_pkg::SUM_W'(prodQ[0]) + bqf_pkg::SUM_W'(prodQ[1])
            + bqf_pkg::SUM_W'(prodQ[2]);
         // sum and scale both carry fraction bits, so both are dropped here
         scaledD = FW'(scaleProd >>> (bqf_pkg::FRAC_W + bqf_pkg::FRAC_W));
         yFbD = ySat;
         yFb2D = yFbQ;
         ovfFbD = ovfRaw;
         yD1D = yFbQ;
         ovfD1D = ovfFbQ;
         yD2D = yD1Q;
         ovfD2D = ovfD1Q;
         // RULE14 flag travels with its sample
         yOutD = yD2Q;
         ovfOutD = ovfD2Q;
         // RULE9 a new sample every cycle that adv is high
         validD = {validQ[bqf_pkg::LATENCY-2:0], 1'b1};
         // RULE8 valid once the first sample leaves the last stage
         outValidD = outValidQ || validQ[bqf_pkg::LATENCY-1];
      end
   end

   // pipeline registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         // RULE10 zero initial state
         for (int i = 0; i < bqf_pkg::TAPS; i++) begin
            xTapQ[i] <= '0;
            ffCoefQ[i] <= '0;
            prodQ[i] <= '0;
         end
         scaleQ <= '0;
         fbOneQ <= '0;
         fbTwoQ <= '0;
         sumQ <= '0;
         scaledQ <= '0;
         yFbQ <= '0;
         yFb2Q <= '0;
         ovfFbQ <= 1'b0;
         yD1Q <= '0;
         yD2Q <= '0;
         yOutQ <= '0;
         ovfD1Q <= 1'b0;
         ovfD2Q <= 1'b0;
         ovfOutQ <= 1'b0;
         validQ <= '0;
         outValidQ <= 1'b0;
      end else begin
         xTapQ <= xTapD;
         ffCoefQ <= ffCoefD;
         prodQ <= prodD;
         scaleQ <= scaleD;
         fbOneQ <= fbOneD;
         fbTwoQ <= fbTwoD;
         sumQ <= sumD;
         scaledQ <= scaledD;
         yFbQ <= yFbD;
         yFb2Q <= yFb2D;
         ovfFbQ <= ovfFbD;
         yD1Q <= yD1D;
         yD2Q <= yD2D;
         yOutQ <= yOutD;
         ovfD1Q <= ovfD1D;
         ovfD2Q <= ovfD2D;
         ovfOutQ <= ovfOutD;
         validQ <= validD;
         outValidQ <= outValidD;
      end
   end

   // RULE5 plain 16-bit signed output, registered
   assign sampleOut = yOutQ;
   assign overflowOut = ovfOutQ;
   assign sampleOutValid = outValidQ;

   // RULE12 output fifo for cascading or draining
   bqf_fifo #(
      .WIDTH(bqf_pkg::FIFO_W),
      .DEPTH(bqf_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .inValid(fifoPush),
      .inReady(fifoInReady),
      .inData({ovfD2Q, yD2Q}),
      .outValid(streamValid),
      .outReady(streamReady),
      .outData(streamData)
   );

   // checks
   a_capture_sample: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE1
      adv |=> xTapQ[0] == $past(sampleIn)) else $error("sample not captured");
   a_tap_product: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE3
      adv |=> prodQ[1] == $past(xTapQ[1]) * $past(ffCoefQ[1])) else $error("bad tap product");
   a_seven_latency: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE8
      (adv ##1 adv[*7]) |=> sampleOutValid && sampleOut == $past(yD2Q))
      else $error("latency wrong");
   a_sat_positive: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
      overflowOut && !sampleOut[15] |-> sampleOut == bqf_pkg::SAT_MAX)
      else $error("positive clamp wrong");
   a_sat_negative: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
      overflowOut && sampleOut[15] |-> sampleOut == bqf_pkg::SAT_MIN)
      else $error("negative clamp wrong");
   a_ovf_aligned: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE14
      overflowOut |-> (sampleOut == bqf_pkg::SAT_MAX || sampleOut == bqf_pkg::SAT_MIN))
      else $error("overflow without clamped sample");
   a_ovf_detect: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE6
      adv && (yFull > FW'(bqf_pkg::SAT_MAX)) |=> ovfFbQ && yFbQ == bqf_pkg::SAT_MAX)
      else $error("overflow missed");
   a_ovf_stage: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE6
      adv |=> ovfFbQ == ($past(yFull) < FW'(bqf_pkg::SAT_MIN) ||
                         $past(yFull) > FW'(bqf_pkg::SAT_MAX))) else $error("flag mismatch");
   a_idle_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE13
      !adv |=> $stable(sampleOut) && $stable(overflowOut) && $stable(yFbQ))
      else $error("state moved while idle");
   a_reset_zero: assert property (@(posedge clk_sys) // RULE10
      !rst_n |=> yFbQ == '0 && yFb2Q == '0 && !overflowOut) else $error("reset not cleared");
   a_no_stall: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE9
      en && sampleReady |=> validQ[0]) else $error("enabled sample refused");
   a_feedback_shift: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
      adv |=> yFb2Q == $past(yFbQ)) else $error("feedback history broken");

   c_overflow: cover property (@(posedge clk_sys) disable iff (!rst_n) overflowOut);
   c_neg_clamp: cover property (@(posedge clk_sys) disable iff (!rst_n)
      sampleOut == bqf_pkg::SAT_MIN && overflowOut);
   c_stall: cover property (@(posedge clk_sys) disable iff (!rst_n) en && !sampleReady);
   c_full_run: cover property (@(posedge clk_sys) disable iff (!rst_n) adv[*8]);
endmodule // bqf_core

//--- dv/bqf_sink.sv
// downstream consumer model that drains the buffered output stream
`timescale 1ns/1ps
module bqf_sink (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // bench control: high holds off the consumer
   input wire logic stall,
   // buffered stream from the section
   input wire logic streamValid,
   input wire logic [16:0] streamData,
   output logic streamReady
);
   // words taken so far, in arrival order
   logic [16:0] words[$];

   // ready is registered, so the consumer answers one cycle late, like real logic
   // stream words recorded for the bench to compare
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         streamReady <= 1'b0;
         words.delete();
      end else begin
         streamReady <= !stall;
         // take the head only on a completed handshake
         if (streamValid && streamReady) begin
            words.push_back(streamData);
         end
      end
   end
endmodule // bqf_sink

//--- dv/bqf_core_tb_top.sv
// self-checking bench for the biquad section and its output stream
`timescale 1ns/1ps
module bqf_core_tb_top;
   // stimulus and observed signals
   logic clk_sys, rst_n, en, stall;
   logic signed [15:0] s0, b0, b1, b2, a1, a2, sampleIn;
   logic [15:0] sampleOut, v;
   logic overflowOut, sampleOutValid, sampleReady, streamValid, streamReady;
   logic [16:0] streamData;
   // expected stream words and reference state
   logic [16:0] expq[$];
   longint mx1, mx2, my1, my2;
   int miscompares, n_checks;

   bqf_core uut (.clk_sys(clk_sys), .rst_n(rst_n), .en(en), .gain_scale_in(s0),
      .ff_tap_zero_in(b0), .ff_tap_one_in(b1), .ff_tap_two_in(b2), .fb_tap_one_in(a1),
      .fb_tap_two_in(a2), .sampleIn(sampleIn), .sampleOut(sampleOut),
      .overflowOut(overflowOut), .sampleOutValid(sampleOutValid),
      .sampleReady(sampleReady), .streamValid(streamValid), .streamReady(streamReady),
      .streamData(streamData));
   bqf_sink sink (.clk_sys(clk_sys), .rst_n(rst_n), .stall(stall),
      .streamValid(streamValid), .streamData(streamData), .streamReady(streamReady));

   // clock at 50 ns period
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // verdict and end of run
   task end_sim;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task chk(input bit ok, input string msg);
      n_checks++;
      if (!ok) begin
         miscompares++;
         $display("Error %0t: %s", $time, msg);
      end
   endtask

   // reference: integer fixed-point taps in 1.2.13, saturated feedback
   function automatic logic [16:0] model(input longint x);
      longint r;
      r = ((s0 * (b0 * x + b1 * mx1 + b2 * mx2)) >>> 26) - ((a1 * my1 + a2 * my2) >>> 13);
      mx2 = mx1;
      mx1 = x;
      my2 = my1;
      my1 = (r > 32767) ? 32767 : (r < -32768) ? -32768 : r;
      return {r != my1, my1[15:0]};
   endfunction

   // reset for n edges, then check cleared outputs and clear the reference
   task do_reset(input int n);
      @(posedge clk_sys);
      #1;
      // reset held low over several edges
      rst_n = 1'b0;
      en = 1'b0;
      repeat (n) @(posedge clk_sys);
      #1;
      chk(sampleOut === 16'h0000 && overflowOut === 1'b0, "output not cleared");
      chk(sampleOutValid === 1'b0 && streamValid === 1'b0, "valid after reset");
      rst_n = 1'b1;
      {mx1, mx2, my1, my2} = '0;
      expq.delete();
   endtask

   // present one sample; it is held until the section can take it
   task feed(input logic signed [15:0] x);
      int k;
      k = 0;
      @(posedge clk_sys);
      #1;
      sampleIn = x;
      en = 1'b1;
      while (sampleReady !== 1'b1 && k < 40) begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      if (k == 40) begin
         chk(1'b0, "input never accepted");
         end_sim();
      end
      expq.push_back(model(x));
   endtask

   task idle(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         #1;
         en = 1'b0;
      end
   endtask

   // push zeros through, drain the stream, compare every word
   task flush_cmp;
      int k;
      repeat (7) feed(16'sh0000);
      k = 0;
      idle(3);
      while (streamValid !== 1'b0 && k < 40) begin
         idle(1);
         k++;
      end
      if (k == 40) begin
         chk(1'b0, "stream never drained");
         end_sim();
      end
      chk(sink.words.size() == expq.size() - 7, "stream word count");
      foreach (sink.words[i]) chk(sink.words[i] === expq[i], "stream word");
   endtask

   // impulse after a reset taken in mid-stream: exact latency, clean state
   task t_latency;
      {s0, b0, b1, b2, a1, a2} = {16'sh2000, 16'sh2000, 16'sh2000, 16'sh0000,
         16'sh2000, 16'sh0000};
      for (int i = 0; i < 9; i++) feed(16'sh3000);
      do_reset(2);
      {b1, a1} = '0;
      feed(16'sh03e8);
      for (int i = 0; i < 8; i++) begin
         feed(16'sh0000);
         if (i == 6) chk(sampleOutValid === 1'b0, "output early");
      end
      chk(sampleOutValid === 1'b1 && sampleOut === 16'h03e8 && overflowOut === 1'b0,
         "first output");
      flush_cmp();
   endtask

   // signed taps and feedback, back to back, with an enable gap
   task t_stream;
      do_reset(2);
      {s0, b0, b1, b2, a1, a2} = {16'sh1000, 16'sh2000, 16'sh4000, 16'sh2000,
         16'she000, 16'sh2000};
      for (int i = 0; i < 10; i++) feed(16'(i * 200 - 900));
      idle(1);
      v = sampleOut;
      idle(5);
      chk(sampleOut === v && sink.words.size() == expq.size() - 7, "moved while idle");
      for (int i = 0; i < 10; i++) feed(16'(600 - i * 150));
      flush_cmp();
   endtask

   // gain of nine around both saturation edges
   task t_ovf;
      int xs[7];
      xs = '{3640, 3641, -3640, -3641, 30000, 100, -30000};
      do_reset(2);
      {s0, b0, b1, b2, a1, a2} = {16'sh6000, 16'sh6000, 64'h0};
      foreach (xs[i]) feed(16'(xs[i]));
      // the second sample reaches the output after three more, the fourth after five
      repeat (3) feed(16'sh0000);
      chk(sampleOut === 16'h7fff && overflowOut === 1'b1, "positive clamp");
      repeat (2) feed(16'sh0000);
      chk(sampleOut === 16'h8000 && overflowOut === 1'b1, "negative clamp");
      flush_cmp();
   endtask

   // consumer stalls until the buffer fills and the section freezes
   task t_fifo;
      do_reset(2);
      {s0, b0, b1, b2, a1, a2} = {16'sh2000, 16'sh2000, 16'sh2000, 48'h0};
      stall = 1'b1;
      for (int i = 0; i < 11; i++) feed(16'(i * 10 + 5));
      idle(2);
      chk(sampleReady === 1'b0 && streamValid === 1'b1, "buffer not full");
      v = sampleOut;
      fork
         feed(16'sh0309);
         begin
            repeat (4) @(posedge clk_sys);
            #1;
            chk(sampleOut === v, "moved while stalled");
            stall = 1'b0;
         end
      join
      flush_cmp();
   endtask

   // watchdog
   initial begin
      #2ms;
      chk(1'b0, "run timed out");
      end_sim();
   end

   // main sequence
   initial begin
      {rst_n, en, stall, sampleIn, s0, b0, b1, b2, a1, a2} = '0;
      miscompares = 0;
      n_checks = 0;
      do_reset(10);
      t_latency();
      t_stream();
      t_ovf();
      t_fifo();
      end_sim();
   end
endmodule // bqf_core_tb_top
